// [src/sbc_boot_top.sv]
`timescale 1ns/100ps
module sbc_boot_top #(
  parameter bit EXT_EEPROM_BUILD = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic ring_clk,
  input wire logic strap_test,
  input wire logic [2:0] config_select_straps,
  input wire logic [1:0] strap_if,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  output logic [6:0] slave_addr,
  output logic iface_spi,
  output logic ref_pin_en,
  output logic xtal_drv_en,
  output logic ref_doubler_on,
  output logic pll_input_doubler_on,
  output logic boot_done_flag,
  output logic ring_osc_en,
  output logic [5:0] strap_status_reg,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic spi_select_low_o,
  output logic spi_select_oe_n,
  output logic sclk_o,
  output logic sclk_oe_n,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i
);
  sbc_fetch_if fetch ();

  // ---------------- reference clock domain ----------------
  logic [5:0] strap_s1_q, strap_s2_q, strap_q;
  logic [1:0] settle_q;
  logic strap_valid_q;
  logic [6:0] slave_addr_reg_q;
  logic slave_written_q;
  logic [1:0] ref_input_mode_q;
  logic ref_doubler_en_q, pll_input_doubler_en_q, ring_osc_disable_q;
  logic boot_done_q;
  logic [7:0] host_rdata_q;
  logic wreq_s1_q, wreq_s2_q, wreq_s3_q, ack_tgl_q;
  logic done_s1_q, done_s2_q;
  logic script_wr;
  logic [6:0] default_addr;
  logic [1:0] if_sel;
  logic wr_en;
  logic [7:0] wr_addr, wr_data;
  logic wr_slave, wr_ref, wr_osc, script_take;
  // ring-domain sources of the write crossing, declared ahead of their readers
  logic req_tgl_q, exec_done_q;
  logic [7:0] exec_wr_addr_q, exec_wr_data_q, ptr_q;

  // straps are pins: synchronise, then latch once after reset release
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_s1_q <= 6'h00;
      strap_s2_q <= 6'h00;
    end else begin
      strap_s1_q <= {strap_test, config_select_straps, strap_if};
      strap_s2_q <= strap_s1_q;
    end
  end

  // spare edges let the synchroniser fill with post-reset pin levels
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q <= 2'h0;
    end else if (ce && settle_q != sbc_pkg::STRAP_SETTLE_CYC) begin
      settle_q <= settle_q + 2'h1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      strap_valid_q <= 1'b0;
      strap_q <= 6'h00;
    end else if (ce && !strap_valid_q && settle_q == sbc_pkg::STRAP_SETTLE_CYC) begin
      strap_q <= strap_s2_q;
      strap_valid_q <= 1'b1;
    end
  end

  assign if_sel = strap_q[sbc_pkg::STRAP_IF_LSB +: 2];

  always_comb begin
    unique case (if_sel)
      2'h0: default_addr = sbc_pkg::SLAVE_ADDR_IF0;
      2'h1: default_addr = sbc_pkg::SLAVE_ADDR_IF1;
      2'h2: default_addr = EXT_EEPROM_BUILD ? sbc_pkg::SLAVE_ADDR_RST : sbc_pkg::SLAVE_ADDR_IF2;
      default: default_addr = sbc_pkg::SLAVE_ADDR_RST;
    endcase
  end

  // script write request: toggle crossing, address and data held by the sender
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wreq_s1_q <= 1'b0;
      wreq_s2_q <= 1'b0;
      wreq_s3_q <= 1'b0;
    end else begin
      wreq_s1_q <= req_tgl_q;
      wreq_s2_q <= wreq_s1_q;
      // a script write that loses to the host stays pending, else boot would hang
      if (ce && !host_wr) begin
        wreq_s3_q <= wreq_s2_q;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      done_s1_q <= 1'b0;
      done_s2_q <= 1'b0;
    end else begin
      done_s1_q <= exec_done_q;
      done_s2_q <= done_s1_q;
    end
  end

  assign script_wr = wreq_s2_q ^ wreq_s3_q;
  assign script_take = ce && script_wr && !host_wr;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_tgl_q <= 1'b0;
    end else if (script_take) begin
      ack_tgl_q <= !ack_tgl_q;
    end
  end

  // host port is served on the reference clock, never the ring oscillator
  assign wr_en = host_wr || script_wr;
  assign wr_addr = host_wr ? host_addr : exec_wr_addr_q;
  assign wr_data = host_wr ? host_wdata : exec_wr_data_q;
  assign wr_slave = ce && wr_en && wr_addr == sbc_pkg::REG_SLAVE;
  assign wr_ref = ce && wr_en && wr_addr == sbc_pkg::REG_REF;
  assign wr_osc = ce && wr_en && wr_addr == sbc_pkg::REG_OSC;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_addr_reg_q <= sbc_pkg::SLAVE_ADDR_RST;
    end else if (wr_slave) begin
      slave_addr_reg_q <= wr_data[6:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      slave_written_q <= 1'b0;
    end else if (wr_slave) begin
      slave_written_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_input_mode_q <= sbc_pkg::REF_MODE_RST;
    end else if (wr_ref) begin
      ref_input_mode_q <= wr_data[sbc_pkg::REF_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_doubler_en_q <= 1'b0;
    end else if (wr_ref) begin
      ref_doubler_en_q <= wr_data[sbc_pkg::REF_DBL_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pll_input_doubler_en_q <= 1'b0;
    end else if (wr_ref) begin
      pll_input_doubler_en_q <= wr_data[sbc_pkg::PLL_DBL_BIT];
    end
  end

  // disable is only accepted once boot is done, so loading cannot stall itself
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ring_osc_disable_q <= 1'b0;
    end else if (wr_osc && boot_done_q) begin
      ring_osc_disable_q <= wr_data[sbc_pkg::OSC_DIS_BIT];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      boot_done_q <= 1'b0;
    end else if (ce && done_s2_q) begin
      boot_done_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata_q <= 8'h00;
    end else if (ce) begin
      case (host_addr)
        sbc_pkg::REG_STRAP: host_rdata_q <= {2'h0, strap_q};
        sbc_pkg::REG_SLAVE: host_rdata_q <= {1'b0, slave_addr};
        sbc_pkg::REG_REF: host_rdata_q <= {4'h0, pll_input_doubler_en_q,
          ref_doubler_en_q, ref_input_mode_q};
        sbc_pkg::REG_OSC: host_rdata_q <= {6'h00, boot_done_q, ring_osc_disable_q};
        default: host_rdata_q <= 8'h00;
      endcase
    end
  end

  assign host_rdata = host_rdata_q;
  assign slave_addr = slave_written_q ? slave_addr_reg_q : default_addr;
  assign iface_spi = (if_sel == sbc_pkg::IF_SPI) ||
    (EXT_EEPROM_BUILD && if_sel == sbc_pkg::IF_EXT_SPI_SLAVE);
  assign ref_pin_en = ref_input_mode_q == sbc_pkg::MODE_PIN;
  assign xtal_drv_en = ref_input_mode_q == sbc_pkg::MODE_XTAL;
  // doubler sits behind the crystal driver or the reference pin only
  assign ref_doubler_on = ref_doubler_en_q && (ref_pin_en || xtal_drv_en);
  assign pll_input_doubler_on = pll_input_doubler_en_q;
  assign boot_done_flag = boot_done_q;
  assign ring_osc_en = !(ring_osc_disable_q && boot_done_q);
  assign strap_status_reg = strap_q;

  // ---------------- ring oscillator domain ----------------
  logic ce_r1_q, ce_r2_q, sv_r1_q, sv_r2_q, ack_r1_q, ack_r2_q;
  logic ext_load;
  logic skip_boot;
  sbc_pkg::sbc_state_t state_q;

  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      ce_r1_q <= 1'b0;
      ce_r2_q <= 1'b0;
    end else begin
      ce_r1_q <= ce;
      ce_r2_q <= ce_r1_q;
    end
  end

  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      sv_r1_q <= 1'b0;
      sv_r2_q <= 1'b0;
    end else begin
      sv_r1_q <= strap_valid_q;
      sv_r2_q <= sv_r1_q;
    end
  end

  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r1_q <= 1'b0;
      ack_r2_q <= 1'b0;
    end else begin
      ack_r1_q <= ack_tgl_q;
      ack_r2_q <= ack_r1_q;
    end
  end

  // strap_q is frozen from the edge that raises strap_valid_q, so it is safe to read here
  assign ext_load = EXT_EEPROM_BUILD && if_sel == sbc_pkg::IF_SPI;
  assign skip_boot = strap_q[sbc_pkg::STRAP_TEST_BIT] &&
    strap_q[sbc_pkg::STRAP_CFG_LSB +: 3] == sbc_pkg::CFG_SKIP;

  // boot controller runs entirely on the ring oscillator
  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= sbc_pkg::SBC_WAIT;
      exec_wr_addr_q <= 8'h00;
      exec_wr_data_q <= 8'h00;
      req_tgl_q <= 1'b0;
    end else if (ce_r2_q) begin
      unique case (state_q)
        sbc_pkg::SBC_WAIT: begin
          if (sv_r2_q) begin
            state_q <= skip_boot ? sbc_pkg::SBC_DONE : sbc_pkg::SBC_FETCH_A;
          end
        end
        sbc_pkg::SBC_FETCH_A: begin
          if (fetch.valid) begin
            exec_wr_addr_q <= fetch.data;
            state_q <= (fetch.data == sbc_pkg::SCRIPT_END) ? sbc_pkg::SBC_DONE :
              sbc_pkg::SBC_FETCH_D;
          end
        end
        sbc_pkg::SBC_FETCH_D: begin
          if (fetch.valid) begin
            exec_wr_data_q <= fetch.data;
            req_tgl_q <= !req_tgl_q;
            state_q <= sbc_pkg::SBC_WRITE;
          end
        end
        sbc_pkg::SBC_WRITE: begin
          if (ack_r2_q == req_tgl_q) begin
            state_q <= (ptr_q == sbc_pkg::SCRIPT_LAST_PTR) ? sbc_pkg::SBC_DONE :
              sbc_pkg::SBC_FETCH_A;
          end
        end
        sbc_pkg::SBC_DONE: state_q <= sbc_pkg::SBC_DONE;
        default: state_q <= sbc_pkg::SBC_WAIT;
      endcase
    end
  end

  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      exec_done_q <= 1'b0;
    end else if (ce_r2_q && state_q == sbc_pkg::SBC_DONE) begin
      exec_done_q <= 1'b1;
    end
  end

  // pairs advance only once the reference side has taken the write
  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      ptr_q <= 8'h00;
    end else if (ce_r2_q && state_q == sbc_pkg::SBC_WRITE && ack_r2_q == req_tgl_q) begin
      ptr_q <= ptr_q + 8'h02;
    end
  end

  assign fetch.req = state_q == sbc_pkg::SBC_FETCH_A || state_q == sbc_pkg::SBC_FETCH_D;
  // each configuration owns a 256-byte page
  assign fetch.addr = {5'h00, strap_q[sbc_pkg::STRAP_CFG_LSB +: 3],
    ptr_q[7:1], state_q == sbc_pkg::SBC_FETCH_D};
  assign fetch.ext_mode = ext_load;
  assign fetch.loading = ext_load && sv_r2_q && state_q != sbc_pkg::SBC_DONE;

  sbc_byte_reader u_reader (
    .ring_clk(ring_clk),
    .rst_n(rst_n),
    .ce(ce_r2_q),
    .fetch(fetch.reader),
    .mem_addr(mem_addr),
    .mem_rdata(mem_rdata),
    .spi_select_low_o(spi_select_low_o),
    .spi_select_oe_n(spi_select_oe_n),
    .sclk_o(sclk_o),
    .sclk_oe_n(sclk_oe_n),
    .mosi_o(mosi_o),
    .mosi_oe_n(mosi_oe_n),
    .miso_i(miso_i)
  );
endmodule

// [src/sbc_pkg.sv]
package sbc_pkg;
  // host and script register map
  localparam logic [7:0] REG_STRAP = 8'h00;
  localparam logic [7:0] REG_SLAVE = 8'h01;
  localparam logic [7:0] REG_REF = 8'h02;
  localparam logic [7:0] REG_OSC = 8'h03;
  // field positions
  localparam int REF_MODE_LSB = 0;
  localparam int REF_DBL_BIT = 2;
  localparam int PLL_DBL_BIT = 3;
  localparam int OSC_DIS_BIT = 0;
  localparam int OSC_DONE_BIT = 1;
  // strap vector layout {test, cfg[2:0], if[1:0]}
  localparam int STRAP_IF_LSB = 0;
  localparam int STRAP_CFG_LSB = 2;
  localparam int STRAP_TEST_BIT = 5;
  // reset values
  localparam logic [1:0] REF_MODE_RST = 2'h0;
  localparam logic [6:0] SLAVE_ADDR_RST = 7'h00;
  // encodings
  localparam logic [6:0] SLAVE_ADDR_IF0 = 7'h74;
  localparam logic [6:0] SLAVE_ADDR_IF1 = 7'h75;
  localparam logic [6:0] SLAVE_ADDR_IF2 = 7'h76;
  localparam logic [1:0] IF_SPI = 2'h3;
  localparam logic [1:0] IF_EXT_SPI_SLAVE = 2'h2;
  localparam logic [1:0] MODE_PIN = 2'h2;
  localparam logic [1:0] MODE_XTAL = 2'h1;
  localparam logic [2:0] CFG_SKIP = 3'h3;
  localparam logic [7:0] SPI_READ_CMD = 8'h03;
  localparam logic [7:0] SCRIPT_END = 8'hFF;
  localparam logic [7:0] SCRIPT_LAST_PTR = 8'hFE;
  // timing counts
  localparam logic [1:0] STRAP_SETTLE_CYC = 2'h2;
  localparam logic [2:0] SCLK_HALF_LAST = 3'h3;
  localparam logic [5:0] SPI_RX_FIRST_BIT = 6'h18;
  localparam logic [5:0] SPI_LAST_BIT = 6'h1F;

  typedef enum logic [2:0] {
    SBC_WAIT = 3'h0,
    SBC_FETCH_A = 3'h1,
    SBC_FETCH_D = 3'h3,
    SBC_WRITE = 3'h2,
    SBC_DONE = 3'h6
  } sbc_state_t;
endpackage

// [src/sbc_fetch_if.sv]
`timescale 1ns/100ps
interface sbc_fetch_if;
  logic req;
  logic [15:0] addr;
  logic ext_mode;
  logic loading;
  logic valid;
  logic [7:0] data;
  modport exec (output req, output addr, output ext_mode, output loading,
    input valid, input data);
  modport reader (input req, input addr, input ext_mode, input loading,
    output valid, output data);
endinterface

// [src/sbc_byte_reader.sv]
`timescale 1ns/100ps
module sbc_byte_reader (
  input wire logic ring_clk,
  input wire logic rst_n,
  input wire logic ce,
  sbc_fetch_if.reader fetch,
  output logic [15:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  output logic spi_select_low_o,
  output logic spi_select_oe_n,
  output logic sclk_o,
  output logic sclk_oe_n,
  output logic mosi_o,
  output logic mosi_oe_n,
  input wire logic miso_i
);
  logic miso_s1_q, miso_s2_q;
  logic mem_busy_q, mem_wait_q, spi_busy_q, valid_q, sclk_q, sel_low_q;
  logic [7:0] data_q, rx_q;
  logic [15:0] mem_addr_q;
  logic [23:0] shift_q;
  logic [5:0] bit_q;
  logic [2:0] div_q;

  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
    end else begin
      miso_s1_q <= miso_i;
      miso_s2_q <= miso_s1_q;
    end
  end

  // internal memory: synchronous read, one cycle latency
  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_busy_q <= 1'b0;
      mem_wait_q <= 1'b0;
      mem_addr_q <= 16'h0000;
    end else if (ce) begin
      if (!mem_busy_q && !spi_busy_q && fetch.req && !valid_q && !fetch.ext_mode) begin
        mem_busy_q <= 1'b1;
        mem_wait_q <= 1'b1;
        mem_addr_q <= fetch.addr;
      end else if (mem_wait_q) begin
        mem_wait_q <= 1'b0;
      end else if (mem_busy_q) begin
        mem_busy_q <= 1'b0;
      end
    end
  end

  // one full read command per byte; slow but needs no stream state
  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      spi_busy_q <= 1'b0;
      sel_low_q <= 1'b1;
      sclk_q <= 1'b0;
      shift_q <= 24'h000000;
      rx_q <= 8'h00;
      bit_q <= 6'h00;
      div_q <= 3'h0;
    end else if (ce) begin
      if (!mem_busy_q && !spi_busy_q && fetch.req && !valid_q && fetch.ext_mode) begin
        spi_busy_q <= 1'b1;
        sel_low_q <= 1'b0;
        shift_q <= {sbc_pkg::SPI_READ_CMD, fetch.addr};
        bit_q <= 6'h00;
        div_q <= 3'h0;
        sclk_q <= 1'b0;
      end else if (spi_busy_q) begin
        div_q <= div_q + 3'h1;
        if (div_q == sbc_pkg::SCLK_HALF_LAST) begin
          div_q <= 3'h0;
          if (!sclk_q) begin
            sclk_q <= 1'b1;
          end else begin
            // sample late in the high half so the synchroniser has settled
            sclk_q <= 1'b0;
            shift_q <= {shift_q[22:0], 1'b0};
            if (bit_q >= sbc_pkg::SPI_RX_FIRST_BIT) begin
              rx_q <= {rx_q[6:0], miso_s2_q};
            end
            if (bit_q == sbc_pkg::SPI_LAST_BIT) begin
              spi_busy_q <= 1'b0;
              sel_low_q <= 1'b1;
            end else begin
              bit_q <= bit_q + 6'h01;
            end
          end
        end
      end
    end
  end

  always_ff @(posedge ring_clk or negedge rst_n) begin
    if (!rst_n) begin
      valid_q <= 1'b0;
      data_q <= 8'h00;
    end else if (ce) begin
      valid_q <= 1'b0;
      if (mem_busy_q && !mem_wait_q) begin
        valid_q <= 1'b1;
        data_q <= mem_rdata;
      end else if (spi_busy_q && sclk_q && bit_q == sbc_pkg::SPI_LAST_BIT &&
                   div_q == sbc_pkg::SCLK_HALF_LAST) begin
        valid_q <= 1'b1;
        data_q <= {rx_q[6:0], miso_s2_q};
      end
    end
  end

  assign fetch.valid = valid_q;
  assign fetch.data = data_q;
  assign mem_addr = mem_addr_q;
  assign spi_select_low_o = sel_low_q;
  assign sclk_o = sclk_q;
  assign mosi_o = shift_q[23];
  // pins are released once loading ends so the host can share the wires
  assign spi_select_oe_n = !fetch.loading;
  assign sclk_oe_n = !fetch.loading;
  assign mosi_oe_n = !fetch.loading;
endmodule

// [dv/sbc_script_mem.sv]
`timescale 1ns/100ps
module sbc_script_mem (
  input wire logic ring_clk,
  input wire logic [15:0] mem_addr,
  output logic [7:0] mem_rdata
);
  // page 0 only sets the reference so the strap default address stays visible
  logic pg0;
  assign pg0 = (mem_addr[15:8] == 8'h00);
  // one page per configuration, pairs of register and data, end marker last
  always_ff @(posedge ring_clk) begin
    case (mem_addr[7:0])
      8'h00: mem_rdata <= pg0 ? sbc_pkg::REG_REF : sbc_pkg::REG_SLAVE;
      8'h01: mem_rdata <= pg0 ? 8'h05 : 8'h10 + mem_addr[15:8];
      8'h02: mem_rdata <= pg0 ? sbc_pkg::SCRIPT_END : sbc_pkg::REG_REF;
      8'h03: mem_rdata <= 8'h06;
      default: mem_rdata <= sbc_pkg::SCRIPT_END;
    endcase
  end
endmodule

// [dv/sbc_boot_sva.sv]
`timescale 1ns/100ps
module sbc_boot_sva #(
  parameter bit EXT_EEPROM_BUILD = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic host_wr,
  input wire logic [7:0] host_addr,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic [6:0] slave_addr,
  input wire logic iface_spi,
  input wire logic ref_pin_en,
  input wire logic xtal_drv_en,
  input wire logic ref_doubler_on,
  input wire logic pll_input_doubler_on,
  input wire logic boot_done_flag,
  input wire logic ring_osc_en,
  input wire logic [5:0] strap_status_reg,
  input wire logic spi_select_oe_n,
  input wire logic sclk_oe_n,
  input wire logic mosi_oe_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_slave_wr;
    ce && host_wr && host_addr == sbc_pkg::REG_SLAVE && !host_wdata[7];
  endsequence
  sequence s_ref_wr;
    ce && host_wr && host_addr == sbc_pkg::REG_REF;
  endsequence
  sequence s_osc_off;
    ce && host_wr && host_addr == sbc_pkg::REG_OSC && host_wdata[0] && boot_done_flag;
  endsequence
  chk_done_sticky: assert property (boot_done_flag |=> boot_done_flag)
    else $error("boot done flag dropped");
  chk_osc_gate: assert property (!ring_osc_en |-> boot_done_flag)
    else $error("ring oscillator stopped before boot done");
  chk_osc_stop: assert property (s_osc_off |=> !ring_osc_en)
    else $error("ring oscillator disable ignored");
  chk_slave_over: assert property (s_slave_wr |=> {1'b0, slave_addr} == $past(host_wdata))
    else $error("slave address write not applied");
  chk_ref_mode: assert property (s_ref_wr |=>
    ref_pin_en == (($past(host_wdata) & 8'h03) == 8'h02) &&
    xtal_drv_en == (($past(host_wdata) & 8'h03) == 8'h01))
    else $error("reference mode enables wrong");
  chk_pll_dbl: assert property (s_ref_wr |=>
    pll_input_doubler_on == (($past(host_wdata) & 8'h08) != 8'h00))
    else $error("pll input doubler wrong");
  chk_dbl_source: assert property (ref_doubler_on |-> ref_pin_en || xtal_drv_en)
    else $error("reference doubler without source");
  chk_strap_read: assert property (ce && host_addr == sbc_pkg::REG_STRAP |=>
    host_rdata == {2'h0, $past(strap_status_reg)})
    else $error("strap status read wrong");
  chk_strap_hold: assert property (boot_done_flag |-> $stable(strap_status_reg))
    else $error("latched straps changed");
  chk_iface_mode: assert property (iface_spi == (strap_status_reg[1:0] == sbc_pkg::IF_SPI ||
    (EXT_EEPROM_BUILD && strap_status_reg[1:0] == sbc_pkg::IF_EXT_SPI_SLAVE)))
    else $error("interface mode wrong");
  chk_spi_release: assert property (boot_done_flag |-> spi_select_oe_n && sclk_oe_n && mosi_oe_n)
    else $error("eeprom lines driven after boot");
endmodule
bind sbc_boot_top sbc_boot_sva #(.EXT_EEPROM_BUILD(EXT_EEPROM_BUILD)) sbc_boot_sva_inst (
  .ref_clk, .rst_n, .ce, .host_wr, .host_addr, .host_wdata, .host_rdata, .slave_addr,
  .iface_spi, .ref_pin_en, .xtal_drv_en, .ref_doubler_on, .pll_input_doubler_on,
  .boot_done_flag, .ring_osc_en, .strap_status_reg, .spi_select_oe_n, .sclk_oe_n,
  .mosi_oe_n);

// [dv/sbc_boot_top_test.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
module sbc_boot_top_test;
  logic ref_clk, rst_n, ring_raw, ring_clk, strap_test, host_wr;
  logic ring_osc_en, boot_done_flag, iface_spi, ref_pin_en, xtal_drv_en;
  logic ref_doubler_on, pll_input_doubler_on;
  logic ce, spi_select_low_o, spi_select_oe_n, sclk_o, sclk_oe_n, mosi_o, mosi_oe_n;
  logic [2:0] config_select_straps;
  logic [1:0] strap_if;
  logic [7:0] host_addr, host_wdata, host_rdata, mem_rdata, r;
  logic [6:0] slave_addr;
  logic [5:0] strap_status_reg;
  logic [15:0] mem_addr;
  logic [7:0] vals [7] = '{8'h02, 8'h01, 8'h06, 8'h05, 8'h04, 8'h08, 8'h03};
  int errors = 0;
  int checked = 0;
  int cycles = 0;
  // the ring clock stops for real when the device disables it
  assign ring_clk = ring_raw & ring_osc_en;
  sbc_boot_top sbc_boot_top_inst (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .ring_clk(ring_clk), .strap_test(strap_test), .config_select_straps(config_select_straps),
    .strap_if(strap_if), .host_wr(host_wr), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .slave_addr(slave_addr), .iface_spi(iface_spi),
    .ref_pin_en(ref_pin_en), .xtal_drv_en(xtal_drv_en), .ref_doubler_on(ref_doubler_on),
    .pll_input_doubler_on(pll_input_doubler_on), .boot_done_flag(boot_done_flag),
    .ring_osc_en(ring_osc_en), .strap_status_reg(strap_status_reg), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .spi_select_low_o(spi_select_low_o),
    .spi_select_oe_n(spi_select_oe_n), .sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n),
    .mosi_o(mosi_o), .mosi_oe_n(mosi_oe_n), .miso_i(1'b1));
  sbc_script_mem sbc_script_mem_inst (.ring_clk(ring_clk), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  initial begin
    ring_raw = 1'b0;
    #3;
    forever #6 ring_raw = ~ring_raw;
  end
  task automatic give_verdict();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 6000) begin
      errors++;
      give_verdict();
    end
  end
  task automatic host_write(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    host_wr = 1'b1;
    host_addr = a;
    host_wdata = d;
    @(negedge ref_clk);
    host_wr = 1'b0;
  endtask
  task automatic host_read(input logic [7:0] a, output logic [7:0] d);
    @(negedge ref_clk);
    host_addr = a;
    @(negedge ref_clk);
    d = host_rdata;
  endtask
  // the early disable write lands before boot is done and must be ignored
  task automatic boot(input logic t, input logic [2:0] c, input logic [1:0] f);
    int n;
    @(negedge ref_clk);
    rst_n = 1'b0;
    strap_test = t;
    config_select_straps = c;
    strap_if = f;
    repeat (5) @(negedge ref_clk);
    rst_n = 1'b1;
    host_write(sbc_pkg::REG_OSC, 8'h01);
    n = 0;
    while (boot_done_flag !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (3) @(negedge ref_clk);
    `CHK(boot_done_flag, 1'b1)
    `CHK(ring_osc_en, 1'b1)
    `CHK(strap_status_reg, {t, c, f})
    `CHK({spi_select_low_o, spi_select_oe_n, sclk_oe_n, mosi_oe_n, sclk_o, mosi_o}, 6'h3C)
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    strap_test = 1'b0;
    config_select_straps = 3'h0;
    strap_if = 2'h0;
    host_wr = 1'b0;
    host_addr = 8'h00;
    host_wdata = 8'h00;
    for (int i = 0; i < 4; i++) begin
      boot(1'b0, 3'h0, 2'(i));
      `CHK(iface_spi, i == 3)
      if (i < 3) `CHK(slave_addr, 7'(7'h74 + i))
      `CHK(xtal_drv_en, 1'b1)
      `CHK(ref_doubler_on, 1'b1)
    end
    for (int c = 1; c < 8; c++) begin
      boot(1'b0, 3'(c), 2'h1);
      `CHK(slave_addr, 7'(7'h10 + c))
      `CHK(ref_pin_en, 1'b1)
    end
    boot(1'b1, 3'h3, 2'h0);
    `CHK(xtal_drv_en, 1'b0)
    `CHK(slave_addr, 7'h74)
    host_read(sbc_pkg::REG_STRAP, r);
    `CHK(r, 8'h2C)
    host_write(sbc_pkg::REG_SLAVE, 8'h2A);
    `CHK(slave_addr, 7'h2A)
    foreach (vals[k]) begin
      host_write(sbc_pkg::REG_REF, vals[k]);
      `CHK(ref_pin_en, vals[k][1:0] == 2'h2)
      `CHK(xtal_drv_en, vals[k][1:0] == 2'h1)
      `CHK(ref_doubler_on, vals[k][2] && vals[k][1:0] inside {2'h1, 2'h2})
      `CHK(pll_input_doubler_on, vals[k][3])
    end
    host_write(sbc_pkg::REG_OSC, 8'h01);
    `CHK(ring_osc_en, 1'b0)
    // host side must keep working with the ring clock stopped
    host_write(sbc_pkg::REG_SLAVE, 8'h33);
    host_read(sbc_pkg::REG_SLAVE, r);
    `CHK(r, 8'h33)
    // with the clock enable low a host write must not land
    ce = 1'b0;
    host_write(sbc_pkg::REG_SLAVE, 8'h44);
    `CHK(slave_addr, 7'h33)
    ce = 1'b1;
    host_read(sbc_pkg::REG_OSC, r);
    `CHK(r, 8'h03)
    host_read(8'h40, r);
    `CHK(r, 8'h00)
    give_verdict();
  end
endmodule
